// ### pkg/sdp_pkg.sv
// What this block does
// [RULE1] The stack pointer is an 8-bit register that starts the stack and resets to 07h.
// [RULE2] Each stack store and subroutine jump increments the stack pointer before its write.
// [RULE3] Each stack load, subroutine exit or interrupt exit decrements it after its read.
// [RULE4] Software writes to the stack pointer relocate where later stack operations land.
// [RULE5] The primary data pointer is 16 bits held as separate low and high byte registers.
// [RULE6] An auxiliary 16-bit data pointer, also split in two bytes, is kept independently.
// [RULE7] With the choice bit set, data-pointer instructions use the auxiliary pair.
// [RULE8] Choice bit 0 selects the primary pair and 1 selects the auxiliary pair.
// [RULE9] Only bit 0 of the selector exists; bits 7 to 1 read zero; it resets to 00h.
// [RULE10] Stack pointer steps wrap modulo 256 and all data pointer bytes reset to zero.
package sdp_pkg;
	localparam logic [7:0] SDP_ADDR_STACK  = 8'h81;
	localparam logic [7:0] SDP_ADDR_A_LOW  = 8'h82;
	localparam logic [7:0] SDP_ADDR_A_HIGH = 8'h83;
	localparam logic [7:0] SDP_ADDR_B_LOW  = 8'h84;
	localparam logic [7:0] SDP_ADDR_B_HIGH = 8'h85;
	localparam logic [7:0] SDP_ADDR_CHOICE = 8'h86;
	localparam logic [7:0] SDP_RST_STACK   = 8'h07;
	localparam logic [7:0] SDP_RST_BYTE    = 8'h00;
	localparam logic [7:0] SDP_RST_CHOICE  = 8'h00;
	localparam int         SDP_CHOICE_BIT  = 0;
	localparam logic [7:0] SDP_STEP        = 8'h01;

	// Stack operation codes from the execution logic
	typedef enum logic [3:0] {
		SDP_STK_NONE  = 4'h1,
		SDP_STK_STORE = 4'h2,
		SDP_STK_LOAD  = 4'h4,
		SDP_STK_BOTH  = 4'h8
	} sdp_stk_type;
endpackage

// ### pkg/sdp_ptr_if.sv
`timescale 1ns/1ns
// One 16-bit pointer: write strobes and current value
interface sdp_ptr_if;
	logic        wr_low;
	logic        wr_high;
	logic        wr_word;
	logic [7:0]  wdata;
	logic [15:0] wword;
	logic [15:0] value;
	modport ctl (output wr_low, output wr_high, output wr_word, output wdata,
		output wword, input value);
	modport reg16 (input wr_low, input wr_high, input wr_word, input wdata,
		input wword, output value);
endinterface

// ### hdl/sdp_ptr_reg.sv
`timescale 1ns/1ns
// Split low/high data pointer pair
module sdp_ptr_reg (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Pointer access
	sdp_ptr_if.reg16 p
);
	logic [7:0] low_q;
	logic [7:0] high_q;

	// Low byte; a whole-word update takes priority over a byte write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_q <= sdp_pkg::SDP_RST_BYTE; // [RULE10]
		end else if (p.wr_word) begin
			low_q <= p.wword[7:0];
		end else if (p.wr_low) begin
			low_q <= p.wdata; // [RULE5]
		end
	end

	// High byte
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			high_q <= sdp_pkg::SDP_RST_BYTE; // [RULE10]
		end else if (p.wr_word) begin
			high_q <= p.wword[15:8];
		end else if (p.wr_high) begin
			high_q <= p.wdata; // [RULE5]
		end
	end

	assign p.value = {high_q, low_q};
endmodule

// ### hdl/sdp_stack_ptr.sv
`timescale 1ns/1ns
// Stack pointer with automatic step
module sdp_stack_ptr (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// Control
	input  wire logic             wr,
	input  wire logic [7:0]       wdata,
	input  wire sdp_pkg::sdp_stk_type op,
	// State
	output logic [7:0]            value
);
	logic [7:0] sp_q;

	// Software write beats a stack step in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sp_q <= sdp_pkg::SDP_RST_STACK; // [RULE1]
		end else if (wr) begin
			sp_q <= wdata; // [RULE4]
		end else begin
			case (op)
				sdp_pkg::SDP_STK_STORE: sp_q <= sp_q + sdp_pkg::SDP_STEP; // [RULE2] [RULE10]
				sdp_pkg::SDP_STK_LOAD:  sp_q <= sp_q - sdp_pkg::SDP_STEP; // [RULE3] [RULE10]
				default:                sp_q <= sp_q;
			endcase
		end
	end

	assign value = sp_q;
endmodule

// ### hdl/sdp_top.sv
`timescale 1ns/1ns
// Stack pointer and dual data pointer register block
module sdp_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Register port from the core
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	// Stack operations
	input  wire logic        stk_push,
	input  wire logic        stk_pop,
	// Active pointer access
	input  wire logic        active_data_pointer_load,
	input  wire logic [15:0] active_data_pointer_wdata,
	// State out
	output logic [7:0]       stack_top_pointer,
	output logic [15:0]      active_data_pointer,
	output logic             pointer_choice
);
	logic                 sel_q;
	logic [7:0]           sp_val;
	sdp_pkg::sdp_stk_type op;
	logic                 hit_sp;
	logic [7:0]           rd_d;
	logic [15:0]          act_d;

	sdp_ptr_if pa ();
	sdp_ptr_if pb ();

	// Push and pop together cancel out
	always_comb begin
		if (stk_push && !stk_pop) begin
			op = sdp_pkg::SDP_STK_STORE; // [RULE2]
		end else if (stk_pop && !stk_push) begin
			op = sdp_pkg::SDP_STK_LOAD; // [RULE3]
		end else begin
			op = sdp_pkg::SDP_STK_NONE;
		end
	end

	assign hit_sp = reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_STACK);

	sdp_stack_ptr u_sp (
		.mclk  (mclk),
		.arst_n(arst_n),
		.wr    (hit_sp),
		.wdata (reg_wdata),
		.op    (op),
		.value (sp_val)
	);

	// Byte writes by address; word loads go to the pair the selector names
	assign pa.wr_low  = reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_A_LOW);
	assign pa.wr_high = reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_A_HIGH);
	assign pa.wr_word = active_data_pointer_load && !sel_q; // [RULE8]
	assign pa.wdata   = reg_wdata;
	assign pa.wword   = active_data_pointer_wdata;
	assign pb.wr_low  = reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_B_LOW);
	assign pb.wr_high = reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_B_HIGH);
	assign pb.wr_word = active_data_pointer_load && sel_q; // [RULE7]
	assign pb.wdata   = reg_wdata;
	assign pb.wword   = active_data_pointer_wdata;

	sdp_ptr_reg u_pa (
		.mclk  (mclk),
		.arst_n(arst_n),
		.p     (pa)
	); // [RULE5]

	sdp_ptr_reg u_pb (
		.mclk  (mclk),
		.arst_n(arst_n),
		.p     (pb)
	); // [RULE6]

	// Selector keeps only bit 0
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= sdp_pkg::SDP_RST_CHOICE[sdp_pkg::SDP_CHOICE_BIT]; // [RULE9]
		end else if (reg_wr && (reg_addr == sdp_pkg::SDP_ADDR_CHOICE)) begin
			sel_q <= reg_wdata[sdp_pkg::SDP_CHOICE_BIT]; // [RULE9]
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			sdp_pkg::SDP_ADDR_STACK:  rd_d = sp_val;
			sdp_pkg::SDP_ADDR_A_LOW:  rd_d = pa.value[7:0];
			sdp_pkg::SDP_ADDR_A_HIGH: rd_d = pa.value[15:8];
			sdp_pkg::SDP_ADDR_B_LOW:  rd_d = pb.value[7:0];
			sdp_pkg::SDP_ADDR_B_HIGH: rd_d = pb.value[15:8];
			sdp_pkg::SDP_ADDR_CHOICE: rd_d = {7'h00, sel_q}; // [RULE9]
			default:                  rd_d = 8'h00;
		endcase
	end

	assign act_d = sel_q ? pb.value : pa.value; // [RULE7] [RULE8]

	// Registered outputs lag state by one cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata           <= 8'h00;
			stack_top_pointer   <= sdp_pkg::SDP_RST_STACK;
			active_data_pointer <= 16'h0000;
			pointer_choice      <= 1'b0;
		end else begin
			reg_rdata           <= rd_d;
			stack_top_pointer   <= sp_val;
			active_data_pointer <= act_d;
			pointer_choice      <= sel_q;
		end
	end
endmodule

// ### test/sdp_checker_assertions.sv
`timescale 1ns/1ns
// Port checks; outputs lag state one edge
module sdp_checker (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// Core requests
	input wire logic        stk_push,
	input wire logic        stk_pop,
	input wire logic        active_data_pointer_load,
	input wire logic [15:0] active_data_pointer_wdata,
	// State
	input wire logic [7:0]  stack_top_pointer,
	input wire logic [15:0] active_data_pointer,
	input wire logic        pointer_choice
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// No other stack pointer cause now or last cycle
	sequence s_calm;
		!reg_wr && !$past(reg_wr) && !$past(stk_push) && !$past(stk_pop);
	endsequence
	property p_rst;
		$rose(arst_n) |-> stack_top_pointer == 8'h07 && active_data_pointer == 16'h0000
			&& !pointer_choice;
	endproperty
	property p_push;
		s_calm ##0 (stk_push && !stk_pop) |=> ##1
			stack_top_pointer == $past(stack_top_pointer, 2) + 8'h01;
	endproperty
	property p_pop;
		s_calm ##0 (stk_pop && !stk_push) |=> ##1
			stack_top_pointer == $past(stack_top_pointer, 2) - 8'h01;
	endproperty
	property p_both;
		s_calm ##0 (stk_pop && stk_push) |=> ##1
			stack_top_pointer == $past(stack_top_pointer, 2);
	endproperty
	property p_spwr;
		reg_wr && reg_addr == 8'h81 |=> ##1 stack_top_pointer == $past(reg_wdata, 2);
	endproperty
	property p_sel;
		reg_wr && reg_addr == 8'h86 |=> ##1 pointer_choice == $past(reg_wdata[0], 2);
	endproperty
	property p_load;
		active_data_pointer_load && !reg_wr |=> ##1 active_data_pointer == $past(active_data_pointer_wdata, 2);
	endproperty
	property p_rd;
		$past(reg_addr) == 8'h86 |-> reg_rdata[7:1] == 7'h00;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset values wrong");
	a_push: assert property (p_push)
		else $error("push step wrong");
	a_pop: assert property (p_pop)
		else $error("pop step wrong");
	a_both: assert property (p_both)
		else $error("push with pop moved");
	a_spwr: assert property (p_spwr)
		else $error("stack write lost");
	a_sel: assert property (p_sel)
		else $error("choice write lost");
	a_load: assert property (p_load)
		else $error("pointer load lost");
	a_rd: assert property (p_rd)
		else $error("choice upper bits set");
	c_push: cover property (stk_push && !stk_pop);
	c_wrap: cover property (stk_push && stack_top_pointer == 8'hFF);
	c_aux: cover property (active_data_pointer_load && pointer_choice);
endmodule
bind sdp_top sdp_checker chk_u (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
	.stk_push, .stk_pop, .active_data_pointer_load, .active_data_pointer_wdata, .stack_top_pointer, .active_data_pointer,
	.pointer_choice);

// ### test/sdp_core_model.sv
`timescale 1ns/1ns
// Execution logic stand-in: one request pulse per command
module sdp_core_model (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic [2:0]  cmd,
	input wire logic [15:0] word,
	output logic            stk_push,
	output logic            stk_pop,
	output logic            active_data_pointer_load,
	output logic [15:0]     active_data_pointer_wdata
);
	// Word bus carries junk outside loads so stale data cannot pass
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{active_data_pointer_load, stk_pop, stk_push} <= 3'h0;
			active_data_pointer_wdata <= 16'h0000;
		end else begin
			{active_data_pointer_load, stk_pop, stk_push} <= cmd;
			active_data_pointer_wdata <= cmd[2] ? word : ~word;
		end
	end
endmodule

// ### test/stack_and_dual_data_pointer_bench.sv
`timescale 1ns/1ns
// Integer model of the pointers compared after each operation
module stack_and_dual_data_pointer_bench;
	logic        mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0;
	logic [7:0]  reg_addr = 8'h80, reg_wdata = 8'h00, reg_rdata, stack_top_pointer;
	logic        stk_push, stk_pop, active_data_pointer_load, pointer_choice;
	logic [15:0] active_data_pointer_wdata, active_data_pointer, word = 16'h0000;
	logic [2:0]  cmd = 3'h0;
	int          fail_count = 0, total_checks = 0, cycles = 0, sp = 7, sel = 0;
	int          dp[2] = '{0, 0};
	always #5 mclk = ~mclk;
	sdp_top dut_u (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .stk_push,
		.stk_pop, .active_data_pointer_load, .active_data_pointer_wdata, .stack_top_pointer, .active_data_pointer,
		.pointer_choice);
	sdp_core_model core_u (.mclk, .arst_n, .cmd, .word, .stk_push, .stk_pop, .active_data_pointer_load,
		.active_data_pointer_wdata);
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string n, input int e, input logic [15:0] g);
		total_checks++;
		if (g !== e[15:0]) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e[15:0], g);
		end
	endtask
	// Register write, then one core command a cycle later, then settle
	task go(input int a, input int wr, input int d, input int c, input int w);
		int i;
		@(posedge mclk);
		reg_addr <= a[7:0];
		reg_wr <= wr[0];
		reg_wdata <= d[7:0];
		cmd <= c[2:0];
		word <= w[15:0];
		@(posedge mclk);
		reg_wr <= 1'b0;
		cmd <= 3'h0;
		repeat (3) @(posedge mclk);
		#1;
		i = (a - 'h82) / 2;
		if (wr[0] && a == 'h81) sp = d;
		if (wr[0] && a == 'h86) sel = d & 1;
		if (wr[0] && a > 'h81 && a < 'h86)
			dp[i] = a[0] ? (dp[i] & 'hFF) | (d << 8) : (dp[i] & 'hFF00) | d;
		if (c[2]) dp[sel] = w;
		sp = (sp + c[0] - c[1] + 256) % 256;
		chk("sp", sp, stack_top_pointer);
		chk("active_data_pointer", dp[sel], active_data_pointer);
		chk("choice", sel, pointer_choice);
		i = a == 'h81 ? sp : a == 'h86 ? sel : a > 'h81 && a < 'h86 ? dp[i] : 0;
		chk("rdata", a > 'h81 && a < 'h86 && a[0] ? i >> 8 : i & 'hFF, reg_rdata);
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 1000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h4261));
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		for (int a = 'h80; a < 'h88; a++) go(a, 0, 0, 0, 0);
		go('h81, 1, 'hFF, 1, 0);
		go('h81, 1, 0, 2, 0);
		go('h86, 1, 'hFF, 4, 'h1234);
		repeat (60) go($urandom_range('h87, 'h80), $urandom_range(1, 0), $urandom_range(255, 0),
			$urandom_range(7, 0), $urandom_range('hFFFF, 0));
		// Mid-run reset must bring the stack pointer, selector and primary pointer back to their start values
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		sp = 7;
		sel = 0;
		dp = '{0, 0};
		go('h86, 0, 0, 0, 0);
		go('h82, 0, 0, 0, 0);
		report_and_stop();
	end
endmodule
